/* ldcl_defines.svh */
// Purpose: register offsets, field positions, reset values and timing for the laser control block
// Assumes: AXI4-Lite, 32-bit data, 25 MHz clock
// Notes: definitions only
`ifndef LDCL_DEFINES_SVH
`define LDCL_DEFINES_SVH

`define LDCL_CLK_HZ 25000000
`define LDCL_CYC_PER_MS (`LDCL_CLK_HZ / 1000)

`define LDCL_OFF_MODE 8'h00
`define LDCL_OFF_CTRL 8'h04
`define LDCL_OFF_STATUS 8'h08
`define LDCL_OFF_PD_OFFSET 8'h0C
`define LDCL_OFF_LD_SETPT 8'h10
`define LDCL_OFF_PD_SETPT 8'h14
`define LDCL_OFF_PW_SETPT 8'h18
`define LDCL_OFF_LD_STEP 8'h1C
`define LDCL_OFF_LD_DELAY 8'h20
`define LDCL_OFF_PD_STEP 8'h24
`define LDCL_OFF_PD_DELAY 8'h28
`define LDCL_OFF_RESP 8'h2C
`define LDCL_OFF_HWCFG 8'h30
`define LDCL_OFF_OUTPUT_ON_DELAY_TIMER 8'h34
`define LDCL_OFF_APPLIED 8'h38
`define LDCL_OFF_PD_MEAS 8'h3C

// mode register: write 0..2 generic, 4/5/6 dedicated entry commands
`define LDCL_MODE_CMD_LD 3'h4
`define LDCL_MODE_CMD_PD 3'h5
`define LDCL_MODE_CMD_PW 3'h6

// control register bits
`define LDCL_CTRL_MOD 0
`define LDCL_CTRL_OUT 1
`define LDCL_CTRL_PDZ 2
`define LDCL_CTRL_RANGE 3
`define LDCL_CTRL_TTL_LSB 4
`define LDCL_CTRL_TTL_MSB 6

// status bits
`define LDCL_ST_OUT 0
`define LDCL_ST_TTL_IN 1
`define LDCL_ST_RAMPING 2

`define LDCL_HWCFG_NORAMP 1

// setpoints in hundredths of mA, uA or mW
`define LDCL_LD_STEP_RST 32'h0000_2710
`define LDCL_PD_STEP_RST 32'h0000_03E8
`define LDCL_DELAY_RST_MS 32'h0000_0064
`define LDCL_PD_OFFSET_MAX 32'h0000_1388
`define LDCL_OUTPUT_ON_DELAY_TIMER_RST_MS 32'h0000_0064

`endif

/* ldcl_pkg.sv */
// Purpose: shared types for the laser control block
// Assumes: nothing
// Notes: ttl mode codes are the wire encoding
package ldcl_pkg;
   typedef enum logic [1:0] {
      LDCL_FB_LD = 2'h0,
      LDCL_FB_PD = 2'h1,
      LDCL_FB_PW = 2'h2
   } ldcl_fb_e;
   typedef enum logic [2:0] {
      LDCL_TTL_LOW = 3'h0,
      LDCL_TTL_HIGH = 3'h1,
      LDCL_TTL_DRV_EN = 3'h2,
      LDCL_TTL_PULSE = 3'h3,
      LDCL_TTL_TRACK = 3'h4,
      LDCL_TTL_TEC_EN = 3'h5
   } ldcl_ttl_e;
   typedef struct packed {
      logic [31:0] step;
      logic [31:0] delay_ms;
      logic [31:0] target;
   } ldcl_ramp_cfg_s;
endpackage

/* ldcl_ms_timer.sv */
// Purpose: millisecond tick divider and countdown for one delay
// Assumes: one clock, synchronous active-low reset
// Notes: done is a one-cycle pulse when the count expires
`timescale 1ns/100ps
`include "ldcl_defines.svh"
module ldcl_ms_timer import ldcl_pkg::*; #(
   parameter int CYC_PER_MS = `LDCL_CYC_PER_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [31:0] ms,
   output logic busy,
   output logic done
);
   initial begin
      if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least 1");
   end
   logic [31:0] pre;
   logic [31:0] left;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre <= 32'h0;
         left <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy <= 1'b1;
            pre <= 32'h0;
            left <= (ms == 32'h0) ? 32'h1 : ms;
         end else if (busy) begin
            if (pre == 32'(CYC_PER_MS - 1)) begin
               pre <= 32'h0;
               left <= left - 32'h1;
               if (left == 32'h1) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end else begin
               pre <= pre + 32'h1;
            end
         end
      end
   end
endmodule // ldcl_ms_timer

/* ldcl_ramp.sv */
// Purpose: steps an applied setpoint toward a target
// Assumes: step is nonzero while ramping
// Notes: a new target restarts from the applied value
`timescale 1ns/100ps
`include "ldcl_defines.svh"
module ldcl_ramp import ldcl_pkg::*; #(
   parameter int CYC_PER_MS = `LDCL_CYC_PER_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic direct,
   input wire ldcl_ramp_cfg_s cfg,
   output logic [31:0] applied,
   output logic ramping
);
   logic tstart;
   logic tdone;
   logic [31:0] goal;
   logic [32:0] sum;
   assign sum = {1'b0, applied} + {1'b0, cfg.step};
   ldcl_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(tstart),
      .ms(cfg.delay_ms),
      .busy(),
      .done(tdone)
   );
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         applied <= 32'h0;
         goal <= 32'h0;
         ramping <= 1'b0;
         tstart <= 1'b0;
      end else begin
         tstart <= 1'b0;
         if (load) begin
            goal <= cfg.target;
            // lower target or ramp disabled goes straight through
            if (direct || cfg.target <= applied) begin
               applied <= cfg.target; // [RQ9]
               ramping <= 1'b0;
            end else begin
               ramping <= 1'b1; // [RQ22]
               tstart <= 1'b1;
            end
         end else if (ramping && tdone) begin
            if (sum >= {1'b0, goal}) begin
               applied <= goal; // [RQ21]
               ramping <= 1'b0;
            end else begin
               applied <= sum[31:0]; // [RQ8]
               tstart <= 1'b1;
            end
         end
      end
   end
   never_over_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ramping |-> applied <= goal) else $error("applied passed target"); // [RQ21]
endmodule // ldcl_ramp

/* ldcl_top.sv */
// Purpose: control state of a laser diode driver behind an AXI4-Lite slave
// Assumes: 25 MHz aclk, synchronous active-low aresetn, host keeps values in range
// Notes: setpoints in hundredths of their unit; analog loops live outside
// What this block does
// [RQ1] dedicated mode commands select current, photodiode current or photodiode power feedback
// [RQ2] power mode with zero responsivity falls back to photodiode current mode
// [RQ3] modulation enable flag, 0 off, 1 on, read back the same
// [RQ4] output turns on only after the on-delay timer expires
// [RQ5] output request 0 off, 1 on; status reports actual output same way
// [RQ6] zero-offset enable flag, 0 off, 1 on, gates stored offset
// [RQ7] offset kept and read in microamps; host supplies 0 to 5000
// [RQ8] with config bit 1 clear, raise setpoint one step per delay
// [RQ9] config bit set or lower target applies the setpoint directly
// [RQ10] current ramp starts only in current mode and keeps stepping after a mode change; defaults 100 mA, 100 ms
// [RQ11] photodiode ramp in either photodiode mode; defaults 10 uA, 100 ms
// [RQ12] ramp step and delay readable separately for both ramps
// [RQ13] range selector 0 is 500 mA, 1 is 1500 mA, readable
// [RQ14] stored setpoint readable for each feedback mode
// [RQ15] ttl output follows mode code 0 to 5
// [RQ16] ttl output mode returns to driver enable after every reset
// [RQ17] ttl input query gives 0 for low, 1 for high
// [RQ18] generic mode selector: 0 current, 1 photodiode current, 2 power
// [RQ19] enabled offset adds to photodiode setpoint, subtracts from measurement
// [RQ20] current ramp suspended while the sweep runs
// [RQ21] final step clamped so applied setpoint never passes target
// [RQ22] new target mid-ramp restarts from applied value
`timescale 1ns/100ps
`include "ldcl_defines.svh"
module ldcl_top import ldcl_pkg::*; #(
   parameter int CYC_PER_MS = `LDCL_CYC_PER_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ttl_in,
   input wire logic pulse_mon,
   input wire logic tec_enabled,
   input wire logic liv_active,
   input wire logic [31:0] pd_raw_meas,
   output logic laser_out_en,
   output logic modulation_enable,
   output logic range_sel,
   output logic ttl_out,
   output ldcl_fb_e fb_mode,
   output logic [31:0] ld_setpt_applied,
   output logic [31:0] pd_setpt_effective
);
   initial begin
      if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least 1");
   end

   // write channel capture: address and data may arrive in either order
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] wval;
   logic wr_ok;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wval[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h0;
      end
   end
   function automatic logic [31:0] merge(input logic [31:0] old);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (w_strb[i]) r[i*8 +: 8] = w_data[i*8 +: 8];
      end
      return r;
   endfunction

   // software-held state
   logic out_req;
   logic pdz_en;
   logic [2:0] ttl_mode;
   logic [31:0] pd_offset;
   logic [31:0] ld_setpt;
   logic [31:0] pd_setpt;
   logic [31:0] pw_setpt;
   logic [31:0] ld_step;
   logic [31:0] ld_delay;
   logic [31:0] pd_step;
   logic [31:0] pd_delay;
   logic [31:0] resp;
   logic [31:0] hwcfg;
   logic [31:0] output_on_delay_timer_ms;
   logic ld_load;
   logic pd_load;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulation_enable <= 1'b0;
         out_req <= 1'b0;
         pdz_en <= 1'b0;
         range_sel <= 1'b0;
         ttl_mode <= LDCL_TTL_DRV_EN; // [RQ16]
         pd_offset <= 32'h0;
         ld_setpt <= 32'h0;
         pd_setpt <= 32'h0;
         pw_setpt <= 32'h0;
         ld_step <= `LDCL_LD_STEP_RST; // [RQ10]
         ld_delay <= `LDCL_DELAY_RST_MS;
         pd_step <= `LDCL_PD_STEP_RST; // [RQ11]
         pd_delay <= `LDCL_DELAY_RST_MS;
         resp <= 32'h0;
         hwcfg <= 32'h0;
         output_on_delay_timer_ms <= `LDCL_OUTPUT_ON_DELAY_TIMER_RST_MS;
         fb_mode <= LDCL_FB_LD;
         ld_load <= 1'b0;
         pd_load <= 1'b0;
         wr_ok <= 1'b1;
      end else begin
         ld_load <= 1'b0;
         pd_load <= 1'b0;
         if (aw_held && w_held && !s_axi_bvalid) begin
            wr_ok <= 1'b1;
            case (aw_addr)
               `LDCL_OFF_MODE: begin
                  case (wval[2:0])
                     3'h0, `LDCL_MODE_CMD_LD: fb_mode <= LDCL_FB_LD; // [RQ1] [RQ18]
                     3'h1, `LDCL_MODE_CMD_PD: fb_mode <= LDCL_FB_PD; // [RQ1] [RQ18]
                     3'h2, `LDCL_MODE_CMD_PW:
                        fb_mode <= (resp == 32'h0) ? LDCL_FB_PD : LDCL_FB_PW; // [RQ2]
                     default: fb_mode <= fb_mode;
                  endcase
               end
               `LDCL_OFF_CTRL: begin
                  modulation_enable <= wval[`LDCL_CTRL_MOD]; // [RQ3]
                  out_req <= wval[`LDCL_CTRL_OUT]; // [RQ5]
                  pdz_en <= wval[`LDCL_CTRL_PDZ]; // [RQ6]
                  range_sel <= wval[`LDCL_CTRL_RANGE]; // [RQ13]
                  if (wval[`LDCL_CTRL_TTL_MSB:`LDCL_CTRL_TTL_LSB] <= 3'(LDCL_TTL_TEC_EN))
                     ttl_mode <= wval[`LDCL_CTRL_TTL_MSB:`LDCL_CTRL_TTL_LSB]; // [RQ15]
               end
               `LDCL_OFF_PD_OFFSET: begin
                  // out-of-range value is the host's fault; saturate rather than wrap
                  pd_offset <= (merge(pd_offset) > `LDCL_PD_OFFSET_MAX) ?
                     `LDCL_PD_OFFSET_MAX : merge(pd_offset); // [RQ7]
               end
               `LDCL_OFF_LD_SETPT: begin
                  ld_setpt <= merge(ld_setpt);
                  ld_load <= 1'b1;
               end
               `LDCL_OFF_PD_SETPT: begin
                  pd_setpt <= merge(pd_setpt);
                  pd_load <= 1'b1;
               end
               `LDCL_OFF_PW_SETPT: begin
                  pw_setpt <= merge(pw_setpt);
                  pd_load <= 1'b1;
               end
               `LDCL_OFF_LD_STEP: ld_step <= merge(ld_step);
               `LDCL_OFF_LD_DELAY: ld_delay <= merge(ld_delay);
               `LDCL_OFF_PD_STEP: pd_step <= merge(pd_step);
               `LDCL_OFF_PD_DELAY: pd_delay <= merge(pd_delay);
               `LDCL_OFF_RESP: resp <= merge(resp);
               `LDCL_OFF_HWCFG: hwcfg <= merge(hwcfg);
               `LDCL_OFF_OUTPUT_ON_DELAY_TIMER: output_on_delay_timer_ms <= merge(output_on_delay_timer_ms);
               default: wr_ok <= 1'b0;
            endcase
         end
      end
   end

   // photodiode target: power setpoint times responsivity in power mode
   logic [63:0] pw_prod;
   logic [31:0] pd_target;
   logic [32:0] pd_sum;
   assign pw_prod = pw_setpt * resp;
   assign pd_target = (fb_mode == LDCL_FB_PW) ? pw_prod[31:0] : pd_setpt;

   // ramps: each starts only in its own modes, else the target goes straight through; only the photodiode ramp reloads on a mode change
   logic ld_ramp_run;
   logic pd_ramp_run;
   logic [31:0] pd_applied;
   logic [31:0] ld_applied;
   logic ld_ramping;
   logic pd_ramping;
   logic ld_direct;
   logic pd_direct;
   logic fb_chg;
   ldcl_fb_e fb_q;
   assign ld_direct = hwcfg[`LDCL_HWCFG_NORAMP] || fb_mode != LDCL_FB_LD
      || liv_active; // [RQ9] [RQ10] [RQ20]
   assign pd_direct = hwcfg[`LDCL_HWCFG_NORAMP] || fb_mode == LDCL_FB_LD; // [RQ11]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_q <= LDCL_FB_LD;
      end else begin
         fb_q <= fb_mode;
      end
   end
   assign fb_chg = fb_q != fb_mode;
   assign ld_ramp_run = ld_load || liv_active;
   assign pd_ramp_run = pd_load || fb_chg;
   ldcl_ramp #(.CYC_PER_MS(CYC_PER_MS)) u_ld_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(ld_ramp_run),
      .direct(ld_direct),
      .cfg('{step: ld_step, delay_ms: ld_delay, target: ld_setpt}),
      .applied(ld_applied),
      .ramping(ld_ramping)
   );
   ldcl_ramp #(.CYC_PER_MS(CYC_PER_MS)) u_pd_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(pd_ramp_run),
      .direct(pd_direct),
      .cfg('{step: pd_step, delay_ms: pd_delay, target: pd_target}),
      .applied(pd_applied),
      .ramping(pd_ramping)
   );
   assign pd_sum = {1'b0, pd_applied} + {1'b0, (pdz_en ? pd_offset : 32'h0)};

   // on-delay: output waits for the timer after an off-to-on request
   logic out_req_q;
   logic od_start;
   logic od_done;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_req_q <= 1'b0;
         od_start <= 1'b0;
         laser_out_en <= 1'b0;
      end else begin
         out_req_q <= out_req;
         od_start <= out_req && !out_req_q;
         if (!out_req) begin
            laser_out_en <= 1'b0;
         end else if (od_done) begin
            laser_out_en <= 1'b1; // [RQ4]
         end
      end
   end
   ldcl_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_output_on_delay_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(od_start),
      .ms(output_on_delay_timer_ms),
      .busy(),
      .done(od_done)
   );

   // ttl_in, pulse_mon and tec_enabled pass two flops before use; liv_active and pd_raw_meas are used directly
   logic [2:0] sync1;
   logic [2:0] sync2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {tec_enabled, pulse_mon, ttl_in};
         sync2 <= sync1;
      end
   end

   // outputs registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ttl_out <= 1'b0;
         ld_setpt_applied <= 32'h0;
         pd_setpt_effective <= 32'h0;
      end else begin
         case (ttl_mode)
            LDCL_TTL_LOW: ttl_out <= 1'b0; // [RQ15]
            LDCL_TTL_HIGH: ttl_out <= 1'b1;
            LDCL_TTL_DRV_EN: ttl_out <= laser_out_en;
            LDCL_TTL_PULSE: ttl_out <= sync2[1];
            LDCL_TTL_TRACK: ttl_out <= sync2[0];
            LDCL_TTL_TEC_EN: ttl_out <= sync2[2];
            default: ttl_out <= 1'b0;
         endcase
         ld_setpt_applied <= ld_applied;
         pd_setpt_effective <= pd_sum[32] ? 32'hFFFF_FFFF : pd_sum[31:0]; // [RQ19]
      end
   end

   // read channel
   logic [31:0] rmux;
   logic r_ok;
   logic [31:0] meas;
   assign meas = (pdz_en && pd_raw_meas > pd_offset) ? pd_raw_meas - pd_offset :
      (pdz_en ? 32'h0 : pd_raw_meas); // [RQ19]
   always_comb begin
      r_ok = 1'b1;
      rmux = 32'h0;
      case (s_axi_araddr)
         `LDCL_OFF_MODE: rmux = {30'h0, fb_mode}; // [RQ18]
         `LDCL_OFF_CTRL: rmux = {25'h0, ttl_mode, range_sel, pdz_en, out_req,
            modulation_enable}; // [RQ3] [RQ13]
         `LDCL_OFF_STATUS: rmux = {29'h0, ld_ramping | pd_ramping, sync2[0],
            laser_out_en}; // [RQ5] [RQ17]
         `LDCL_OFF_PD_OFFSET: rmux = pd_offset; // [RQ7]
         `LDCL_OFF_LD_SETPT: rmux = ld_setpt; // [RQ14]
         `LDCL_OFF_PD_SETPT: rmux = pd_setpt; // [RQ14]
         `LDCL_OFF_PW_SETPT: rmux = pw_setpt; // [RQ14]
         `LDCL_OFF_LD_STEP: rmux = ld_step; // [RQ12]
         `LDCL_OFF_LD_DELAY: rmux = ld_delay; // [RQ12]
         `LDCL_OFF_PD_STEP: rmux = pd_step; // [RQ12]
         `LDCL_OFF_PD_DELAY: rmux = pd_delay; // [RQ12]
         `LDCL_OFF_RESP: rmux = resp;
         `LDCL_OFF_HWCFG: rmux = hwcfg;
         `LDCL_OFF_OUTPUT_ON_DELAY_TIMER: rmux = output_on_delay_timer_ms;
         `LDCL_OFF_APPLIED: rmux = ld_applied;
         `LDCL_OFF_PD_MEAS: rmux = meas;
         default: r_ok = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= r_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   sequence req_rise_s;
      out_req && !out_req_q;
   endsequence
   out_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
      req_rise_s |=> !laser_out_en [*2]) else $error("output on before delay"); // [RQ4]
   out_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !out_req |=> !laser_out_en) else $error("output stayed on"); // [RQ4]
   pw_fallback_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(fb_mode) && fb_mode == LDCL_FB_PW |-> resp != 32'h0)
      else $error("power mode entered with zero responsivity"); // [RQ2]
   ttl_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(ttl_mode) == 3'(LDCL_TTL_LOW) |-> !ttl_out) else $error("ttl not low"); // [RQ15]
   ttl_drv_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(ttl_mode) == 3'(LDCL_TTL_DRV_EN) |-> ttl_out == $past(laser_out_en))
      else $error("ttl not tracking enable"); // [RQ15]
   ttl_reset_a: assert property (@(posedge aclk)
      !aresetn |=> ttl_mode == 3'(LDCL_TTL_DRV_EN)) else $error("ttl mode not reset"); // [RQ16]
   offset_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pd_offset <= `LDCL_PD_OFFSET_MAX) else $error("offset out of range"); // [RQ7]
   liv_direct_a: assert property (@(posedge aclk) disable iff (!aresetn)
      liv_active ##1 liv_active |-> !ld_ramping) else $error("ramp ran during sweep"); // [RQ20]
endmodule // ldcl_top

/* ldcl_host.sv */
// Purpose: host-side AXI4-Lite master for the laser control block
// Assumes: whole 32-bit words
// Notes: ok low on timeout
`timescale 1ns/100ps
module ldcl_host (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic ok);
      ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                     output logic ok);
      ok = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
            ok = 1'b1;
         end
      end
   endtask
endmodule // ldcl_host

/* testbench.sv */
// Purpose: self-checking bench
// Assumes: CYC_PER_MS of 2
// Notes: host model speaks the register bus
`timescale 1ns/100ps
`include "ldcl_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t: got %0h exp %0h", $time, g, e); end end
module testbench import ldcl_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ttl_in = 1'b0, pulse_mon = 1'b0, tec_enabled = 1'b1, liv_active = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, ld_setpt_applied;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
   logic laser_out_en, modulation_enable, range_sel, ttl_out;
   ldcl_fb_e fb_mode;
   int err_total = 0, samples_checked = 0;
   always #20 aclk = ~aclk;
   ldcl_top #(.CYC_PER_MS(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ttl_in,
      .pulse_mon, .tec_enabled, .liv_active, .pd_raw_meas(32'h0), .laser_out_en,
      .modulation_enable, .range_sel, .ttl_out, .fb_mode, .ld_setpt_applied,
      .pd_setpt_effective());
   ldcl_host h (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic ok;
      h.wr(a, d, ok);
      if (!ok) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic rx(input logic [7:0] a, output logic [31:0] d);
      logic ok;
      h.rd(a, d, last_resp, ok);
      if (!ok) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic t_reset;
      logic [7:0] a [4] = '{8'h1C, 8'h20, 8'h24, 8'h28};
      logic [31:0] e [4] = '{`LDCL_LD_STEP_RST, 32'h64, `LDCL_PD_STEP_RST, 32'h64};
      logic [31:0] v;
      rx(`LDCL_OFF_CTRL, v);
      `CHK(v[6:4], 3'h2)
      for (int i = 0; i < 4; i++) begin
         rx(a[i], v);
         `CHK(v, e[i])
      end
      rx(8'h40, v);
      `CHK(last_resp, 2'h2)
      $display("reset done");
   endtask
   task automatic t_mode;
      logic [31:0] v;
      w(`LDCL_OFF_RESP, 32'h0);
      w(`LDCL_OFF_MODE, 32'h6);
      repeat (2) @(posedge aclk);
      `CHK(fb_mode, LDCL_FB_PD)
      w(`LDCL_OFF_RESP, 32'h64);
      for (int c = 4; c < 7; c++) begin
         w(`LDCL_OFF_MODE, c);
         repeat (2) @(posedge aclk);
         `CHK(fb_mode, ldcl_fb_e'(c - 4))
      end
      for (int c = 0; c < 3; c++) begin
         w(`LDCL_OFF_MODE, c);
         rx(`LDCL_OFF_MODE, v);
         `CHK(v[1:0], 2'(c))
         `CHK(fb_mode, ldcl_fb_e'(c))
      end
      $display("mode done");
   endtask
   task automatic t_ttl;
      logic e [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      logic [31:0] v;
      ttl_in <= 1'b1;
      for (int c = 0; c < 6; c++) begin
         w(`LDCL_OFF_CTRL, 32'h9 | (c << 4));
         repeat (6) @(posedge aclk);
         `CHK(ttl_out, e[c])
      end
      `CHK({modulation_enable, range_sel}, 2'h3)
      rx(`LDCL_OFF_STATUS, v);
      `CHK(v[1], 1'b1)
      ttl_in <= 1'b0;
      w(`LDCL_OFF_CTRL, 32'h20);
      repeat (4) @(posedge aclk);
      `CHK({modulation_enable, range_sel}, 2'h0)
      rx(`LDCL_OFF_STATUS, v);
      `CHK(v[1], 1'b0)
      rx(`LDCL_OFF_CTRL, v);
      `CHK(v[6:0], 7'h20)
      $display("ttl done");
   endtask
   task automatic t_out;
      logic [31:0] v;
      int n;
      w(`LDCL_OFF_OUTPUT_ON_DELAY_TIMER, 32'h3);
      w(`LDCL_OFF_CTRL, 32'h22);
      for (n = 0; n < 100 && laser_out_en !== 1'b1; n++) @(posedge aclk);
      `CHK(n > 6 && n < 20, 1'b1)
      rx(`LDCL_OFF_STATUS, v);
      `CHK(v[0], 1'b1)
      `CHK(ttl_out, 1'b1)
      w(`LDCL_OFF_CTRL, 32'h20);
      repeat (2) @(posedge aclk);
      `CHK(laser_out_en, 1'b0)
      $display("output done");
   endtask
   task automatic t_store;
      logic [31:0] v;
      w(`LDCL_OFF_PD_OFFSET, 32'h1388); // host keeps offset at most 5000
      rx(`LDCL_OFF_PD_OFFSET, v);
      `CHK(v, 32'h1388)
      w(`LDCL_OFF_CTRL, 32'h24);
      rx(`LDCL_OFF_CTRL, v);
      `CHK(v[2], 1'b1)
      for (int i = 1; i < 3; i++) begin
         w(8'h10 + 8'(4 * i), 32'h11 + i);
         rx(8'h10 + 8'(4 * i), v);
         `CHK(v, 32'h11 + i)
      end
      $display("store done");
   endtask
   task automatic t_ramp;
      logic over = 1'b0;
      w(`LDCL_OFF_MODE, 32'h0);
      w(`LDCL_OFF_LD_STEP, 32'h64); // host keeps step and delay in range
      w(`LDCL_OFF_LD_DELAY, 32'h1);
      w(`LDCL_OFF_LD_SETPT, 32'hFA);
      `CHK(ld_setpt_applied < 32'hFA, 1'b1)
      for (int n = 0; n < 300 && ld_setpt_applied !== 32'hFA; n++) begin
         @(posedge aclk);
         if (ld_setpt_applied > 32'hFA) over = 1'b1;
      end
      `CHK(over, 1'b0)
      `CHK(ld_setpt_applied, 32'hFA)
      w(`LDCL_OFF_LD_SETPT, 32'h32);
      repeat (3) @(posedge aclk);
      `CHK(ld_setpt_applied, 32'h32)
      liv_active <= 1'b1;
      w(`LDCL_OFF_LD_SETPT, 32'h3E8);
      repeat (3) @(posedge aclk);
      `CHK(ld_setpt_applied, 32'h3E8)
      liv_active <= 1'b0;
      w(`LDCL_OFF_HWCFG, 32'h2);
      w(`LDCL_OFF_LD_SETPT, 32'h7D0);
      repeat (3) @(posedge aclk);
      `CHK(ld_setpt_applied, 32'h7D0)
      $display("ramp done");
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_mode();
      t_ttl();
      t_out();
      t_store();
      t_ramp();
      print_verdict();
   end
endmodule // testbench
